/* pkg/prog_port_pkg.sv */
// constants, encodings and state codes of the parallel programming port
package prog_port_pkg;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS   = 40;
  localparam int STROBE_MIN_NS   = 250;
  localparam int ENTRY_GUARD_NS  = 100;
  localparam int ENTRY_GUARD_CYC = (ENTRY_GUARD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ENTRY_WAIT_US   = 50;

  // ----------------------------------------
  // command bytes
  // ----------------------------------------
  localparam logic [7:0] CMD_NOP      = 8'h00;
  localparam logic [7:0] CMD_ERASE    = 8'h80;
  localparam logic [7:0] CMD_WR_FUSE  = 8'h40;
  localparam logic [7:0] CMD_WR_LOCK  = 8'h20;
  localparam logic [7:0] CMD_WR_FLASH = 8'h10;
  localparam logic [7:0] CMD_WR_EE    = 8'h11;
  localparam logic [7:0] CMD_RD_SIG   = 8'h08;
  localparam logic [7:0] CMD_RD_FUSE  = 8'h04;
  localparam logic [7:0] CMD_RD_FLASH = 8'h02;
  localparam logic [7:0] CMD_RD_EE    = 8'h03;

  // ----------------------------------------
  // pin encodings
  // ----------------------------------------
  typedef enum logic [1:0] {
    ACT_ADDR = 2'h0,
    ACT_DATA = 2'h1,
    ACT_CMD  = 2'h2,
    ACT_IDLE = 2'h3
  } action_t;

  localparam logic [1:0] BSEL_LOW  = 2'h0;
  localparam logic [1:0] BSEL_HIGH = 2'h1;
  localparam logic [1:0] BSEL_EXT  = 2'h2;
  localparam logic [1:0] BSEL_ALT  = 2'h3;
  localparam logic [3:0] ENTRY_PATTERN = 4'h0;

  // ----------------------------------------
  // reset and erased values, field positions
  // ----------------------------------------
  localparam logic [7:0]  FUSE_LO_RST  = 8'h62;
  localparam logic [7:0]  FUSE_HI_RST  = 8'h99;
  localparam logic [7:0]  FUSE_EXT_RST = 8'hff;
  localparam logic [7:0]  LOCK_RST     = 8'hff;
  localparam logic [7:0]  ERASED_BYTE  = 8'hff;
  localparam logic [15:0] ERASED_WORD  = 16'hffff;
  localparam int          EE_KEEP_BIT  = 3;
  localparam int          FLASH_PAGE_AW = 7;
  localparam int          EE_PAGE_AW    = 3;

  // ----------------------------------------
  // control states
  // ----------------------------------------
  typedef enum logic [2:0] {
    ST_OFF      = 3'h0,
    ST_ENTRY    = 3'h1,
    ST_IDLE     = 3'h2,
    ST_ER_FLASH = 3'h3,
    ST_ER_EE    = 3'h4,
    ST_PG_FLASH = 3'h5,
    ST_PG_EE    = 3'h6,
    ST_FAIL     = 3'h7
  } state_t;

endpackage : prog_port_pkg

/* pkg/mem_if.sv */
// write and registered read port of a small memory
`timescale 1ns/1ns
interface mem_if #(
  parameter int AW = 8,
  parameter int DW = 8
);
  logic          we;
  logic [AW-1:0] waddr;
  logic [DW-1:0] wdata;
  logic [AW-1:0] raddr;
  logic [DW-1:0] rdata;

  modport ctrl (output we, output waddr, output wdata, output raddr, input rdata);
  modport mem  (input we, input waddr, input wdata, input raddr, output rdata);
endinterface : mem_if

/* verilog/nv_mem.sv */
// simple memory array with one write port and a registered read port
`timescale 1ns/1ns
module nv_mem
  import prog_port_pkg::*;
#(
  parameter int AW = 8,
  parameter int DW = 8
) (
  input wire logic clk,
  mem_if.mem       bus
);

  logic [DW-1:0] cells [2**AW];

  // write then registered read, read-before-write on same address
  always_ff @(posedge clk) begin
    if (bus.we) begin
      cells[bus.waddr] <= bus.wdata;
    end
    bus.rdata <= cells[bus.raddr];
  end

endmodule : nv_mem

/* verilog/parallel_program_port.sv */
// parallel high-voltage programming port: entry, loading, commands, erase, page writes
`timescale 1ns/1ns
module parallel_program_port
  import prog_port_pkg::*;
#(
  parameter int         FLASH_AW = 15,
  parameter int         EE_AW    = 11,
  parameter logic [7:0] SIG_0    = 8'h5a,
  parameter logic [7:0] SIG_1    = 8'h3c,
  parameter logic [7:0] SIG_2    = 8'h0f,
  parameter logic [7:0] CAL_BYTE = 8'h80
) (
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic       program_clock_pin,
  input  wire logic       hv_reset,
  input  wire logic       oe_n,
  input  wire logic       wr_n,
  input  wire logic       byte_select_lo,
  input  wire logic       byte_select_hi,
  input  wire logic       action_select_0,
  input  wire logic       action_select_1,
  input  wire logic       page_latch_strobe,
  input  wire logic [7:0] data_in,
  output logic      [7:0] data_out,
  output logic            data_oe,
  output logic            ready_busy_n,
  output logic            prog_mode
);
  // signature values above are arbitrary

  localparam int CW = FLASH_AW + 1;
  localparam logic [CW-1:0] FLASH_LAST = CW'((2 ** FLASH_AW) - 1);
  localparam logic [CW-1:0] EE_LAST    = CW'((2 ** EE_AW) - 1);
  localparam logic [CW-1:0] PAGE_END   = CW'(2 ** FLASH_PAGE_AW);
  localparam logic [CW-1:0] EE_PG_LAST = CW'((2 ** EE_PAGE_AW) - 1);
  localparam logic [CW-1:0] GUARD_LAST = CW'(ENTRY_GUARD_CYC - 1);

  // ----------------------------------------
  // byte selection shared by reads
  // ----------------------------------------
  function automatic logic [7:0] pick_byte(input logic hi, input logic [15:0] w);
    pick_byte = hi ? w[15:8] : w[7:0];
  endfunction : pick_byte

  // ----------------------------------------
  // link domain: capture on each clock pin pulse
  // ----------------------------------------
  logic [11:0] cap_reg;
  logic        tog_reg;

  // pins are stable around the pulse; word held until the next pulse
  always_ff @(posedge program_clock_pin or negedge rst_b) begin
    if (!rst_b) begin
      cap_reg <= 12'h000;
      tog_reg <= 1'b0;
    end else begin
      cap_reg <= {action_select_1, action_select_0, byte_select_hi, byte_select_lo, data_in};
      tog_reg <= ~tog_reg;
    end
  end

  // ----------------------------------------
  // synchronisers for pins and the load toggle
  // ----------------------------------------
  logic [8:0] sync1_reg;
  logic [8:0] sync2_reg;
  logic [8:0] pins_raw;

  assign pins_raw = {tog_reg, page_latch_strobe, action_select_1, action_select_0,
                     byte_select_hi, byte_select_lo, wr_n, oe_n, hv_reset};

  // two stages, first stage read by nothing else
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sync1_reg <= 9'h006;
      sync2_reg <= 9'h006;
    end else begin
      sync1_reg <= pins_raw;
      sync2_reg <= sync1_reg;
    end
  end

  logic       hv_s;
  logic       oe_n_s;
  logic       wr_n_s;
  logic [1:0] bs_s;
  logic [3:0] pattern_s;
  logic       pl_s;
  logic       tog_s;

  assign hv_s      = sync2_reg[0];
  assign oe_n_s    = sync2_reg[1];
  assign wr_n_s    = sync2_reg[2];
  assign bs_s      = sync2_reg[4:3];
  assign pattern_s = {sync2_reg[7], sync2_reg[6], sync2_reg[5], sync2_reg[3]};
  assign pl_s      = sync2_reg[7];
  assign tog_s     = sync2_reg[8];

  // ----------------------------------------
  // memories: flash, eeprom, flash page buffer
  // ----------------------------------------
  mem_if #(.AW(FLASH_AW), .DW(16))           fl_bus ();
  mem_if #(.AW(EE_AW), .DW(8))               ee_bus ();
  mem_if #(.AW(FLASH_PAGE_AW), .DW(16))      pb_bus ();

  nv_mem #(.AW(FLASH_AW), .DW(16))      u_flash (.clk(clk), .bus(fl_bus.mem));
  nv_mem #(.AW(EE_AW), .DW(8))          u_eeprom (.clk(clk), .bus(ee_bus.mem));
  nv_mem #(.AW(FLASH_PAGE_AW), .DW(16)) u_page (.clk(clk), .bus(pb_bus.mem));

  // ----------------------------------------
  // control state
  // ----------------------------------------
  state_t        state_reg,   state_next;
  logic [7:0]    cmd_reg,     cmd_next;
  logic [23:0]   addr_reg,    addr_next;
  logic [15:0]   dat_reg,     dat_next;
  logic [7:0]    fuse_lo_reg, fuse_lo_next;
  logic [7:0]    fuse_hi_reg, fuse_hi_next;
  logic [7:0]    fuse_ex_reg, fuse_ex_next;
  logic [7:0]    lock_reg,    lock_next;
  logic [CW-1:0] cnt_reg,     cnt_next;
  logic          dirty_reg,   dirty_next;
  logic [2:0]    prev_reg,    prev_next;
  logic [7:0]    dout_reg,    dout_next;
  logic          doe_reg,     doe_next;
  logic          rdy_reg,     rdy_next;
  logic          mode_reg,    mode_next;
  logic [7:0]    eebuf_reg [2**EE_PAGE_AW];
  logic [7:0]    eebuf_next [2**EE_PAGE_AW];

  logic          load_ev;
  logic          wr_fall;
  logic          pl_rise;
  logic [1:0]    cap_bs;
  action_t       cap_act;
  logic [7:0]    cap_dat;
  logic [7:0]    sig_byte;

  assign load_ev = tog_s ^ prev_reg[0];
  assign pl_rise = pl_s & ~prev_reg[1];
  assign wr_fall = prev_reg[2] & ~wr_n_s;
  assign cap_act = action_t'(cap_reg[11:10]);
  assign cap_bs  = cap_reg[9:8];
  assign cap_dat = cap_reg[7:0];

  // next-state, loads, commands and read mux
  always_comb begin
    state_next   = state_reg;
    cmd_next     = cmd_reg;
    addr_next    = addr_reg;
    dat_next     = dat_reg;
    fuse_lo_next = fuse_lo_reg;
    fuse_hi_next = fuse_hi_reg;
    fuse_ex_next = fuse_ex_reg;
    lock_next    = lock_reg;
    cnt_next     = cnt_reg;
    dirty_next   = dirty_reg;
    eebuf_next   = eebuf_reg;
    prev_next    = {wr_n_s, pl_s, tog_s};
    fl_bus.we    = 1'b0;
    fl_bus.waddr = addr_reg[FLASH_AW-1:0];
    fl_bus.wdata = ERASED_WORD;
    fl_bus.raddr = addr_reg[FLASH_AW-1:0];
    ee_bus.we    = 1'b0;
    ee_bus.waddr = addr_reg[EE_AW-1:0];
    ee_bus.wdata = ERASED_BYTE;
    ee_bus.raddr = addr_reg[EE_AW-1:0];
    pb_bus.we    = 1'b0;
    pb_bus.waddr = addr_reg[FLASH_PAGE_AW-1:0];
    pb_bus.wdata = dat_reg;
    pb_bus.raddr = cnt_reg[FLASH_PAGE_AW-1:0];
    case (state_reg)
      ST_OFF: begin
        if (hv_s && pattern_s == ENTRY_PATTERN) begin
          state_next = ST_ENTRY;
          cnt_next   = '0;
        end
      end
      ST_ENTRY: begin
        if (!hv_s) begin
          state_next = ST_OFF;
        end else if (pattern_s != ENTRY_PATTERN) begin
          state_next = ST_FAIL;
        end else if (cnt_reg == GUARD_LAST) begin
          state_next = ST_IDLE;
          cmd_next   = CMD_NOP;
          dirty_next = 1'b0;
        end else begin
          cnt_next = cnt_reg + 1'b1;
        end
      end
      ST_FAIL: begin
        if (!hv_s) begin
          state_next = ST_OFF;
        end
      end
      ST_IDLE: begin
        if (!hv_s) begin
          state_next = ST_OFF;
        end else begin
          // pulse on the clock pin: address, data or command load
          if (load_ev) begin
            case (cap_act)
              ACT_ADDR: begin
                case (cap_bs)
                  BSEL_LOW:  addr_next[7:0]   = cap_dat;
                  BSEL_HIGH: addr_next[15:8]  = cap_dat;
                  BSEL_EXT:  addr_next[23:16] = cap_dat;
                  default:   addr_next        = addr_reg;
                endcase
              end
              ACT_DATA: begin
                if (!cap_bs[1]) begin
                  if (cap_bs[0]) begin
                    dat_next[15:8] = cap_dat;
                  end else begin
                    dat_next[7:0] = cap_dat;
                  end
                end
              end
              ACT_CMD: begin
                cmd_next = cap_dat;
                if (cap_dat == CMD_NOP) begin
                  dirty_next = 1'b0;
                end
              end
              default: cmd_next = cmd_reg;
            endcase
          end
          // page latch pulse fills the page buffers
          if (pl_rise) begin
            if (cmd_reg == CMD_WR_FLASH) begin
              pb_bus.we  = 1'b1;
              dirty_next = 1'b1;
            end else if (cmd_reg == CMD_WR_EE) begin
              eebuf_next[addr_reg[EE_PAGE_AW-1:0]] = dat_reg[7:0];
              dirty_next = 1'b1;
            end
          end
          // write pulse runs the loaded command
          if (wr_fall) begin
            case (cmd_reg)
              CMD_ERASE: begin
                state_next = ST_ER_FLASH;
                cnt_next   = '0;
              end
              CMD_WR_FUSE: begin
                case (bs_s)
                  BSEL_LOW:  fuse_lo_next = dat_reg[7:0];
                  BSEL_HIGH: fuse_hi_next = dat_reg[7:0];
                  BSEL_EXT:  fuse_ex_next = dat_reg[7:0];
                  default:   fuse_lo_next = fuse_lo_reg;
                endcase
              end
              CMD_WR_LOCK: lock_next = lock_reg & dat_reg[7:0];
              CMD_WR_FLASH: begin
                if (dirty_reg) begin
                  state_next = ST_PG_FLASH;
                  cnt_next   = '0;
                end
              end
              CMD_WR_EE: begin
                if (dirty_reg) begin
                  state_next = ST_PG_EE;
                  cnt_next   = '0;
                end
              end
              default: state_next = ST_IDLE;
            endcase
          end
        end
      end
      ST_ER_FLASH: begin
        fl_bus.we    = 1'b1;
        fl_bus.waddr = cnt_reg[FLASH_AW-1:0];
        if (cnt_reg == FLASH_LAST) begin
          cnt_next = '0;
          if (fuse_hi_reg[EE_KEEP_BIT]) begin
            state_next = ST_ER_EE;
          end else begin
            lock_next  = LOCK_RST;
            state_next = ST_IDLE;
          end
        end else begin
          cnt_next = cnt_reg + 1'b1;
        end
      end
      ST_ER_EE: begin
        ee_bus.we    = 1'b1;
        ee_bus.waddr = cnt_reg[EE_AW-1:0];
        if (cnt_reg == EE_LAST) begin
          lock_next  = LOCK_RST;
          state_next = ST_IDLE;
        end else begin
          cnt_next = cnt_reg + 1'b1;
        end
      end
      ST_PG_FLASH: begin
        // buffer read leads the flash write by one cycle
        fl_bus.we    = (cnt_reg != '0);
        fl_bus.waddr = {addr_reg[FLASH_AW-1:FLASH_PAGE_AW], FLASH_PAGE_AW'(cnt_reg - 1'b1)};
        fl_bus.wdata = pb_bus.rdata;
        if (cnt_reg == PAGE_END) begin
          state_next = ST_IDLE;
          dirty_next = 1'b0;
        end else begin
          cnt_next = cnt_reg + 1'b1;
        end
      end
      ST_PG_EE: begin
        ee_bus.we    = 1'b1;
        ee_bus.waddr = {addr_reg[EE_AW-1:EE_PAGE_AW], cnt_reg[EE_PAGE_AW-1:0]};
        ee_bus.wdata = eebuf_reg[cnt_reg[EE_PAGE_AW-1:0]];
        if (cnt_reg == EE_PG_LAST) begin
          state_next = ST_IDLE;
          dirty_next = 1'b0;
        end else begin
          cnt_next = cnt_reg + 1'b1;
        end
      end
      default: state_next = ST_OFF;
    endcase

    // status and read path
    mode_next = (state_next != ST_OFF) && (state_next != ST_ENTRY) && (state_next != ST_FAIL);
    rdy_next  = (state_next != ST_ER_FLASH) && (state_next != ST_ER_EE) &&
                (state_next != ST_PG_FLASH) && (state_next != ST_PG_EE);
    doe_next  = mode_next && !oe_n_s;
    case (addr_reg[1:0])
      2'h0:    sig_byte = SIG_0;
      2'h1:    sig_byte = SIG_1;
      2'h2:    sig_byte = SIG_2;
      default: sig_byte = ERASED_BYTE;
    endcase
    case (cmd_reg)
      CMD_RD_FLASH: dout_next = pick_byte(bs_s[0], fl_bus.rdata);
      CMD_RD_EE:    dout_next = ee_bus.rdata;
      CMD_RD_SIG:   dout_next = pick_byte(bs_s[0], {CAL_BYTE, sig_byte});
      CMD_RD_FUSE: begin
        case (bs_s)
          BSEL_LOW:  dout_next = fuse_lo_reg;
          BSEL_HIGH: dout_next = lock_reg;
          BSEL_EXT:  dout_next = fuse_ex_reg;
          default:   dout_next = fuse_hi_reg;
        endcase
      end
      default: dout_next = 8'h00;
    endcase
  end

  // register all control state
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg   <= ST_OFF;
      cmd_reg     <= CMD_NOP;
      addr_reg    <= 24'h00_0000;
      dat_reg     <= 16'h0000;
      fuse_lo_reg <= FUSE_LO_RST;
      fuse_hi_reg <= FUSE_HI_RST;
      fuse_ex_reg <= FUSE_EXT_RST;
      lock_reg    <= LOCK_RST;
      cnt_reg     <= '0;
      dirty_reg   <= 1'b0;
      prev_reg    <= 3'h4;
      dout_reg    <= 8'h00;
      doe_reg     <= 1'b0;
      rdy_reg     <= 1'b1;
      mode_reg    <= 1'b0;
      for (int i = 0; i < 2 ** EE_PAGE_AW; i++) begin
        eebuf_reg[i] <= ERASED_BYTE;
      end
    end else begin
      state_reg   <= state_next;
      cmd_reg     <= cmd_next;
      addr_reg    <= addr_next;
      dat_reg     <= dat_next;
      fuse_lo_reg <= fuse_lo_next;
      fuse_hi_reg <= fuse_hi_next;
      fuse_ex_reg <= fuse_ex_next;
      lock_reg    <= lock_next;
      cnt_reg     <= cnt_next;
      dirty_reg   <= dirty_next;
      prev_reg    <= prev_next;
      dout_reg    <= dout_next;
      doe_reg     <= doe_next;
      rdy_reg     <= rdy_next;
      mode_reg    <= mode_next;
      eebuf_reg   <= eebuf_next;
    end
  end

  assign data_out     = dout_reg;
  assign data_oe      = doe_reg;
  assign ready_busy_n = rdy_reg;
  assign prog_mode    = mode_reg;

endmodule : parallel_program_port

/* verification/prog_port_checker.sv */
// assertions on the pins of the programming port
`timescale 1ns/1ns
module prog_port_checker #(
  parameter int FLASH_AW = 15,
  parameter int EE_AW    = 11
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic hv_reset,
  input wire logic oe_n,
  input wire logic wr_n,
  input wire logic byte_select_lo,
  input wire logic action_select_0,
  input wire logic action_select_1,
  input wire logic page_latch_strobe,
  input wire logic data_oe,
  input wire logic ready_busy_n,
  input wire logic prog_mode
);
  localparam int ER_A = 2**FLASH_AW;
  localparam int ER_B = ER_A + 2**EE_AW;
  logic [3:0] entry_pins;
  int         busy_cnt;

  // ----------------------------------------
  // helper logic
  // ----------------------------------------
  assign entry_pins = {page_latch_strobe, action_select_1, action_select_0, byte_select_lo};
  // length of the current busy phase
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) busy_cnt <= 0;
    else busy_cnt <= ready_busy_n ? 0 : busy_cnt + 1;
  end

  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  property p_bus_release;
    oe_n [*5] |-> !data_oe;
  endproperty
  a_bus_release: assert property (p_bus_release) else $error("bus driven with oe_n high");
  property p_bus_mode;
    !prog_mode [*5] |-> !data_oe;
  endproperty
  a_bus_mode: assert property (p_bus_mode) else $error("bus driven outside programming mode");
  property p_bus_cause;
    $rose(data_oe) |-> !$past(oe_n, 2) && prog_mode;
  endproperty
  a_bus_cause: assert property (p_bus_cause) else $error("bus driven without oe_n");
  property p_busy_cause;
    $fell(ready_busy_n) |-> !$past(wr_n, 2) && prog_mode;
  endproperty
  a_busy_cause: assert property (p_busy_cause) else $error("busy without write pulse");
  property p_busy_len;
    $rose(ready_busy_n) |-> busy_cnt inside {8, 129, ER_A, ER_B};
  endproperty
  a_busy_len: assert property (p_busy_len) else $error("busy phase of wrong length");
  property p_busy_min;
    $fell(ready_busy_n) |=> !ready_busy_n [*7];
  endproperty
  a_busy_min: assert property (p_busy_min) else $error("busy phase too short");
  property p_entry_ok;
    $rose(prog_mode) |-> $past(hv_reset, 5) && $past(entry_pins, 4) == 4'h0 && $past(entry_pins, 5) == 4'h0;
  endproperty
  a_entry_ok: assert property (p_entry_ok) else $error("entry without clean pattern");
  property p_entry_end;
    !hv_reset [*5] |-> !prog_mode;
  endproperty
  a_entry_end: assert property (p_entry_end) else $error("mode kept without high voltage");
endmodule : prog_port_checker

/* verification/programmer_model.sv */
// model of the external programmer driving the pins
`timescale 1ns/1ns
module programmer_model (
  input  wire logic clk,
  output logic      program_clock_pin,
  output logic      hv_reset,
  output logic      oe_n,
  output logic      wr_n,
  output logic      byte_select_lo,
  output logic      byte_select_hi,
  output logic      action_select_0,
  output logic      action_select_1,
  output logic      page_latch_strobe,
  output logic [7:0] drv_data
);
  localparam int TL = 48; // link time unit; clock pin pulse is 6 units low then 6 units high
  logic [7:0] bus_reg;

  // with oe_n low the model shows the inverse of the last value; released (oe_n high) it shows the value itself
  assign drv_data = oe_n ? bus_reg : ~bus_reg;
  initial begin
    {program_clock_pin, hv_reset, page_latch_strobe, wr_n, oe_n} = 5'h03;
    {byte_select_hi, byte_select_lo, action_select_1, action_select_0} = 4'h0;
    bus_reg = 8'h00;
  end

  // one link clock pulse, still outside frames
  task automatic pulse();
    #(6*TL) program_clock_pin = 1'b1;
    #(6*TL) program_clock_pin = 1'b0;
  endtask : pulse

  // entry sequence, optionally with a pin glitch
  task automatic enter(input bit glitch);
    hv_reset = 1'b0;
    repeat (6) pulse();
    {page_latch_strobe, action_select_1, action_select_0, byte_select_lo} = 4'h0;
    #(3*TL) hv_reset = 1'b1;
    if (glitch) #(TL) action_select_0 = 1'b1;
    else #50000;
  endtask : enter

  // action, byte select and data, then a clock pulse
  task automatic load(input logic [1:0] act, input logic [1:0] bs, input logic [7:0] b);
    @(negedge clk);
    {action_select_1, action_select_0} = act;
    {byte_select_hi, byte_select_lo} = bs;
    bus_reg = b;
    pulse();
    #(6*TL);
  endtask : load

  // low write pulse
  task automatic wr(input logic [1:0] bs);
    @(negedge clk);
    {byte_select_hi, byte_select_lo} = bs;
    wr_n = 1'b0;
    repeat (7) @(negedge clk);
    wr_n = 1'b1;
  endtask : wr

  // page latch pulse
  task automatic latch();
    @(negedge clk);
    page_latch_strobe = 1'b1;
    repeat (7) @(negedge clk);
    page_latch_strobe = 1'b0;
    #(6*TL);
  endtask : latch

  // output enable level and byte select for a read
  task automatic oe_set(input logic lvl, input logic [1:0] bs);
    {byte_select_hi, byte_select_lo} = bs;
    oe_n = lvl;
  endtask : oe_set
endmodule : programmer_model

/* verification/testbench.sv */
// self-checking testbench of the programming port
`timescale 1ns/1ns
module testbench;
  import prog_port_pkg::*;
  localparam int FLASH_AW = 8;
  localparam int EE_AW    = 4;
  localparam logic [7:0] SIG [4] = '{8'h5a, 8'h3c, 8'h0f, 8'h80}; // arbitrary values
  logic       clk, rst_b, program_clock_pin, hv_reset, oe_n, wr_n, page_latch_strobe;
  logic       byte_select_lo, byte_select_hi, action_select_0, action_select_1;
  logic       data_oe, ready_busy_n, prog_mode;
  logic [7:0] drv_data, data_in, data_out;
  int         error_cnt, samples_checked, busy_len;

  parallel_program_port #(.FLASH_AW(FLASH_AW), .EE_AW(EE_AW), .SIG_0(SIG[0]), .SIG_1(SIG[1]),
    .SIG_2(SIG[2]), .CAL_BYTE(SIG[3])) dut (.clk, .rst_b, .program_clock_pin, .hv_reset, .oe_n,
    .wr_n, .byte_select_lo, .byte_select_hi, .action_select_0, .action_select_1,
    .page_latch_strobe, .data_in, .data_out, .data_oe, .ready_busy_n, .prog_mode);
  programmer_model prog (.clk, .program_clock_pin, .hv_reset, .oe_n, .wr_n, .byte_select_lo,
    .byte_select_hi, .action_select_0, .action_select_1, .page_latch_strobe, .drv_data);

  // shared data bus and busy length
  assign data_in = data_oe ? data_out : drv_data;
  always @(posedge clk) if (!ready_busy_n) busy_len++;
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : end_of_test

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // read one byte with the output enable
  task automatic rd(input logic [1:0] bs, input logic [7:0] exp);
    @(negedge clk);
    prog.oe_set(1'b0, bs);
    repeat (6) @(negedge clk);
    check({7'h00, data_oe, data_out}, {8'h01, exp});
    prog.oe_set(1'b1, bs);
    repeat (5) @(negedge clk);
  endtask : rd

  // write pulse, bounded wait for ready, busy length compared
  task automatic run_wr(input logic [1:0] bs, input int exp);
    int n;
    n = 0;
    busy_len = 0;
    prog.wr(bs);
    while (!ready_busy_n && n < 2000) begin
      @(negedge clk);
      n++;
    end
    if (n == 2000) begin
      error_cnt++;
      end_of_test();
    end
    repeat (2) @(negedge clk);
    check(16'(busy_len), 16'(exp));
  endtask : run_wr

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_entry();
    prog.enter(1'b1);
    repeat (20) @(negedge clk);
    check(16'(prog_mode), 16'h0000);
    prog.enter(1'b0);
    check(16'(prog_mode), 16'h0001);
    $display("test entry done");
  endtask : t_entry

  task automatic t_fuse_sig();
    prog.load(ACT_CMD, BSEL_LOW, CMD_RD_FUSE);
    rd(BSEL_LOW, FUSE_LO_RST);
    rd(BSEL_HIGH, LOCK_RST);
    rd(BSEL_EXT, FUSE_EXT_RST);
    rd(BSEL_ALT, FUSE_HI_RST);
    prog.load(ACT_CMD, BSEL_LOW, CMD_RD_SIG);
    prog.load(ACT_ADDR, BSEL_HIGH, 8'h00);
    for (int i = 0; i < 3; i++) begin
      prog.load(ACT_ADDR, BSEL_LOW, 8'(i));
      rd(BSEL_LOW, SIG[i]);
    end
    prog.load(ACT_ADDR, BSEL_LOW, 8'h00);
    rd(BSEL_HIGH, SIG[3]);
    $display("test fuse and signature done");
  endtask : t_fuse_sig

  task automatic t_erase();
    prog.load(ACT_CMD, BSEL_LOW, CMD_WR_LOCK);
    prog.load(ACT_DATA, BSEL_LOW, 8'hfc);
    run_wr(BSEL_LOW, 0);
    prog.load(ACT_CMD, BSEL_LOW, CMD_RD_FUSE);
    rd(BSEL_HIGH, 8'hfc);
    prog.load(ACT_CMD, BSEL_LOW, CMD_ERASE);
    run_wr(BSEL_LOW, 2**FLASH_AW + 2**EE_AW);
    prog.load(ACT_CMD, BSEL_LOW, CMD_RD_FLASH);
    prog.load(ACT_ADDR, BSEL_LOW, 8'h25);
    rd(BSEL_LOW, ERASED_BYTE);
    rd(BSEL_HIGH, ERASED_BYTE);
    prog.load(ACT_CMD, BSEL_LOW, CMD_RD_EE);
    rd(BSEL_LOW, ERASED_BYTE);
    prog.load(ACT_CMD, BSEL_LOW, CMD_RD_FUSE);
    rd(BSEL_HIGH, LOCK_RST);
    rd(BSEL_ALT, FUSE_HI_RST);
    $display("test erase done");
  endtask : t_erase

  task automatic t_flash();
    prog.load(ACT_CMD, BSEL_LOW, CMD_WR_FLASH);
    for (int i = 0; i < 2; i++) begin
      prog.load(ACT_ADDR, BSEL_LOW, 8'(8'h80 + i));
      prog.load(ACT_DATA, BSEL_LOW, 8'(8'h34 + i));
      prog.load(ACT_DATA, BSEL_HIGH, 8'h12);
      prog.latch();
    end
    run_wr(BSEL_LOW, 129);
    prog.load(ACT_CMD, BSEL_LOW, CMD_NOP);
    prog.load(ACT_CMD, BSEL_LOW, CMD_WR_FLASH);
    run_wr(BSEL_LOW, 0);
    prog.load(ACT_CMD, BSEL_LOW, CMD_RD_FLASH);
    prog.load(ACT_ADDR, BSEL_LOW, 8'h81);
    prog.load(ACT_ADDR, BSEL_ALT, 8'h00);
    prog.load(ACT_IDLE, BSEL_LOW, 8'h7f);
    rd(BSEL_LOW, 8'h35);
    rd(BSEL_HIGH, 8'h12);
    $display("test flash done");
  endtask : t_flash

  task automatic t_eeprom();
    prog.load(ACT_CMD, BSEL_LOW, CMD_WR_EE);
    prog.load(ACT_ADDR, BSEL_LOW, 8'h03);
    prog.load(ACT_DATA, BSEL_LOW, 8'ha5);
    prog.latch();
    run_wr(BSEL_LOW, 8);
    prog.load(ACT_CMD, BSEL_LOW, CMD_WR_FUSE);
    prog.load(ACT_DATA, BSEL_LOW, 8'hf7);
    run_wr(BSEL_HIGH, 0);
    run_wr(BSEL_EXT, 0);
    prog.load(ACT_CMD, BSEL_LOW, CMD_ERASE);
    run_wr(BSEL_LOW, 2**FLASH_AW);
    prog.load(ACT_CMD, BSEL_LOW, CMD_RD_EE);
    rd(BSEL_LOW, 8'ha5);
    prog.load(ACT_CMD, BSEL_LOW, CMD_RD_FUSE);
    rd(BSEL_ALT, 8'hf7);
    rd(BSEL_EXT, 8'hf7);
    rd(BSEL_LOW, FUSE_LO_RST);
    $display("test eeprom keep done");
  endtask : t_eeprom

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    error_cnt = 0;
    samples_checked = 0;
    busy_len = 0;
    rst_b = 1'b0;
    repeat (4) @(posedge clk);
    @(negedge clk);
    rst_b = 1'b1;
    t_entry();
    t_fuse_sig();
    t_erase();
    t_flash();
    t_eeprom();
    end_of_test();
  end
endmodule : testbench

bind parallel_program_port prog_port_checker #(.FLASH_AW(FLASH_AW), .EE_AW(EE_AW)) chk (
  .clk, .rst_b, .hv_reset, .oe_n, .wr_n, .byte_select_lo, .action_select_0,
  .action_select_1, .page_latch_strobe, .data_oe, .ready_busy_n, .prog_mode);
